// ===== rtl/dtrwb_pkg.sv
package dtrwb_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Buffer and block geometry
	localparam int BUF_BYTES   = 65536;
	localparam int BLK_BYTES   = 512;
	localparam int MAX_BLOCKS  = 256;
	localparam int RATIO_SCALE = 256;

	////////////////////////////////////////////////////////////////////////////////
	// Command block fields
	localparam logic [7:0] OP_READ     = 8'h08;
	localparam logic [7:0] OP_WRITE    = 8'h0A;
	localparam logic [7:0] OP_SEEK     = 8'h0B;
	localparam logic [7:0] OP_INQUIRY  = 8'h12;
	localparam int         LBA_TOP_MSB = 4;
	localparam logic [8:0] ZERO_LEN_BLOCKS = 9'h100;

	////////////////////////////////////////////////////////////////////////////////
	// Identify message
	localparam int DISC_BIT = 6;

	////////////////////////////////////////////////////////////////////////////////
	// Identification header
	localparam int         INQ_HDR_BYTES   = 5;
	localparam logic [7:0] INQ_PERIPH_TYPE = 8'h00;
	localparam logic [7:0] INQ_MEDIUM_BYTE = 8'h00;
	localparam logic [7:0] INQ_VERSION     = 8'h01;
	localparam logic [7:0] INQ_FORMAT      = 8'h01;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] lun_lba;
		logic [7:0] lba_mid;
		logic [7:0] lba_low;
		logic [7:0] length;
		logic [7:0] control;
	} dtrwb_cdb_type;

	typedef struct packed {
		logic [20:0] lba;
		logic [8:0]  blocks;
	} dtrwb_xfer_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE,
		ST_SEEK,
		ST_INQ,
		ST_DONE
	} dtrwb_state_type;

endpackage : dtrwb_pkg

// ===== rtl/dtrwb_core.sv
`timescale 1ns/100ps
// Summary of operation
// R1 - One 64 KiB buffer stages all data
// R2 - Send read block only once fully fetched
// R3 - Disk fills while blocks remain and room
// R4 - Bus drains until disk done and empty
// R5 - Disconnect only if identify bit 6 set
// R6 - Read: disconnect when buffer empties early
// R7 - Read: reselect at full-ratio level
// R8 - Disk keeps filling while reselection pends
// R9 - Opcode 0A writes; length zero means 256
// R10 - Address from byte 1 bits 4-0, 2, 3
// R11 - Write: stop taking bus data when full
// R12 - Write to disk while data and on-track
// R13 - Write: disconnect when full or all received
// R14 - Write: reconnect at empty-ratio level
// R15 - Opcode 0B seeks, no data moved
// R16 - Opcode 12 queries; allocation zero returns nothing
// R17 - Query returns lesser of allocation and available
// R18 - Initiator should allocate 130 query bytes
// R19 - Bytes 0, 1 of header are zero
// R20 - Byte 2 is 01, format 1, length byte 4
// R21 - Opcode 08 reads, same layout as write
// R22 - Read length zero means 256 blocks
// R23 - Byte occupancy counter against scaled ratios
module dtrwb_core #(
	parameter int BUF_BYTES_P   = dtrwb_pkg::BUF_BYTES,
	parameter int BLK_BYTES_P   = dtrwb_pkg::BLK_BYTES,
	parameter int INQ_ADD_LEN_P = 0
) (
	// Clock and reset
	input  wire logic                      ref_clk_in,
	input  wire logic                      rst_in,
	// Command blocks
	input  wire logic                      cdb_valid_in,
	input  wire dtrwb_pkg::dtrwb_cdb_type  cdb_in,
	output logic                           cmd_ready_out,
	output logic                           cmd_done_out,
	// Identify message and mode ratios
	input  wire logic                      ident_valid_in,
	input  wire logic [7:0]                ident_msg_in,
	input  wire logic [7:0]                full_ratio_in,
	input  wire logic [7:0]                empty_ratio_in,
	// Disk to buffer
	input  wire logic                      disk_rd_valid_in,
	input  wire logic [7:0]                disk_rd_data_in,
	input  wire logic                      disk_blk_ok_in,
	output logic                           disk_rd_ready_out,
	// Buffer to disk
	output logic                           disk_wr_valid_out,
	output logic [7:0]                     disk_wr_data_out,
	input  wire logic                      disk_wr_ready_in,
	input  wire logic                      head_on_target_in,
	// Positioning
	output logic                           xfer_start_out,
	output logic                           seek_req_out,
	output dtrwb_pkg::dtrwb_xfer_type      xfer_out,
	// Bus to buffer
	input  wire logic                      bus_wr_valid_in,
	input  wire logic [7:0]                bus_wr_data_in,
	output logic                           bus_wr_ready_out,
	// Buffer to bus
	output logic                           bus_rd_valid_out,
	output logic [7:0]                     bus_rd_data_out,
	input  wire logic                      bus_rd_ready_in,
	// Connection control and status
	output logic                           disconnect_out,
	output logic                           reselect_req_out,
	input  wire logic                      reselect_done_in,
	output logic [$clog2(BUF_BYTES_P):0]   buf_level_out
);
	import dtrwb_pkg::*;

	localparam int AW = $clog2(BUF_BYTES_P);
	localparam int BW = $clog2(BLK_BYTES_P);
	localparam int XW = $clog2(MAX_BLOCKS * BLK_BYTES_P + 1);
	localparam logic [AW:0]   FULL_LEVEL = (AW+1)'(BUF_BYTES_P);
	localparam logic [AW:0]   BLK_ROLL   = (AW+1)'(BLK_BYTES_P - 1);
	localparam logic [BW-1:0] BLK_LAST   = BW'(BLK_BYTES_P - 1);
	localparam logic [7:0]    INQ_AVAIL  = 8'(INQ_HDR_BYTES + INQ_ADD_LEN_P);

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic [8:0] blocks_of(input logic [7:0] len);
		blocks_of = (len == 8'h00) ? ZERO_LEN_BLOCKS : {1'b0, len};
	endfunction : blocks_of

	function automatic logic [AW:0] ratio_level(input logic [7:0] ratio);
		ratio_level = (AW+1)'(ratio) * (AW+1)'(BUF_BYTES_P / RATIO_SCALE);
	endfunction : ratio_level

	function automatic logic [7:0] inq_byte(input logic [7:0] idx);
		case (idx)
			8'h00:   inq_byte = INQ_PERIPH_TYPE;
			8'h01:   inq_byte = INQ_MEDIUM_BYTE;
			8'h02:   inq_byte = INQ_VERSION;
			8'h03:   inq_byte = INQ_FORMAT;
			8'h04:   inq_byte = 8'(INQ_ADD_LEN_P);
			default: inq_byte = 8'h00;
		endcase
	endfunction : inq_byte

	////////////////////////////////////////////////////////////////////////////////
	// State

	dtrwb_state_type st_reg;
	dtrwb_state_type st_next;
	logic [7:0]      mem [BUF_BYTES_P];
	logic [AW-1:0]   wr_ptr_reg;
	logic [AW-1:0]   rd_ptr_reg;
	logic [AW:0]     occ_reg;
	logic [BW-1:0]   blk_byte_reg;
	logic [8:0]      blocks_left_reg;
	logic [XW-1:0]   bus_left_reg;
	logic [7:0]      inq_left_reg;
	logic [7:0]      inq_idx_reg;
	logic            ov_reg;
	logic [7:0]      od_reg;
	logic            disc_ok_reg;
	logic            disc_reg;
	logic            resel_reg;
	logic            seek_reg;
	logic            start_reg;
	dtrwb_xfer_type  xfer_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Command decode

	wire            cmd_take   = cdb_valid_in & (st_reg == ST_IDLE);
	wire [7:0]      op         = cdb_in.opcode;
	wire            op_read    = (op == OP_READ);
	wire            op_write   = (op == OP_WRITE);
	wire            op_seek    = (op == OP_SEEK);
	wire            op_inq     = (op == OP_INQUIRY);
	wire [8:0]      cmd_blocks = blocks_of(cdb_in.length);
	wire [20:0]     cmd_lba    = {cdb_in.lun_lba[LBA_TOP_MSB:0], cdb_in.lba_mid,
		cdb_in.lba_low};
	wire [XW-1:0]   cmd_bytes  = XW'(cmd_blocks) * XW'(BLK_BYTES_P);
	wire [7:0]      cmd_alloc  = (cdb_in.length < INQ_AVAIL) ? cdb_in.length : INQ_AVAIL;

	////////////////////////////////////////////////////////////////////////////////
	// Buffer flow

	wire            is_rd     = (st_reg == ST_READ);
	wire            is_wr     = (st_reg == ST_WRITE);
	wire            is_inq    = (st_reg == ST_INQ);
	wire            buf_full  = (occ_reg == FULL_LEVEL);
	wire [AW:0]     avail     = occ_reg - (AW+1)'(blk_byte_reg);
	wire            dfire     = disk_rd_valid_in & disk_rd_ready_out;
	wire            blk_end   = dfire & (blk_byte_reg == BLK_LAST);
	wire            commit    = blk_end & disk_blk_ok_in;
	wire            bad       = blk_end & ~disk_blk_ok_in;
	wire            wfire     = bus_wr_valid_in & bus_wr_ready_out;
	wire            buf_wr    = is_rd ? dfire : wfire;
	wire [7:0]      buf_wd    = is_rd ? disk_rd_data_in : bus_wr_data_in;
	wire            take      = is_wr ? disk_wr_ready_in : (bus_rd_ready_in & ~disc_reg);
	wire            src_rd    = is_rd & (avail != '0);
	wire            src_wr    = is_wr & (occ_reg != '0) & head_on_target_in;
	wire            src_inq   = is_inq & (inq_left_reg != 8'h00);
	wire            load      = (src_rd | src_wr | src_inq) & (~ov_reg | take);
	wire            buf_rd    = load & ~is_inq;
	wire [AW:0]     occ_inc   = (AW+1)'(buf_wr & ~bad);
	wire [AW:0]     occ_dec   = (AW+1)'(buf_rd);
	wire [AW:0]     occ_roll  = bad ? BLK_ROLL : '0;
	wire [AW:0]     occ_next  = occ_reg + occ_inc - occ_dec - occ_roll;

	assign disk_rd_ready_out = is_rd & (blocks_left_reg != '0) & ~buf_full; // R3 R8
	assign bus_wr_ready_out  = is_wr & ~disc_reg & (bus_left_reg != '0) & ~buf_full; // R11
	assign bus_rd_valid_out  = ov_reg & (is_rd | is_inq) & ~disc_reg;
	assign disk_wr_valid_out = ov_reg & is_wr; // R12
	assign bus_rd_data_out   = od_reg;
	assign disk_wr_data_out  = od_reg;
	assign buf_level_out     = occ_reg;

	always_ff @(posedge ref_clk_in) begin
		if (buf_wr) begin
			mem[wr_ptr_reg] <= buf_wd; // R1
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			occ_reg    <= '0;
		end else begin
			wr_ptr_reg <= bad ? wr_ptr_reg - AW'(BLK_BYTES_P - 1) : wr_ptr_reg + AW'(buf_wr); // R2
			rd_ptr_reg <= rd_ptr_reg + AW'(buf_rd);
			occ_reg    <= occ_next; // R23
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			ov_reg <= 1'b0;
			od_reg <= 8'h00;
		end else begin
			ov_reg <= load | (ov_reg & ~take);
			if (load) begin
				od_reg <= is_inq ? inq_byte(inq_idx_reg) : mem[rd_ptr_reg]; // R2 R4 R19 R20
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transfer counters

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			blk_byte_reg    <= '0;
			blocks_left_reg <= '0;
			bus_left_reg    <= '0;
		end else if (cmd_take) begin
			blk_byte_reg    <= '0;
			blocks_left_reg <= op_read ? cmd_blocks : '0; // R21 R22
			bus_left_reg    <= op_write ? cmd_bytes : '0; // R9
		end else begin
			if (dfire) begin
				blk_byte_reg <= blk_end ? '0 : blk_byte_reg + 1'b1;
			end
			blocks_left_reg <= blocks_left_reg - 9'(commit); // R2 R3
			bus_left_reg    <= bus_left_reg - XW'(wfire);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			inq_left_reg <= 8'h00;
			inq_idx_reg  <= 8'h00;
		end else if (cmd_take) begin
			inq_left_reg <= op_inq ? cmd_alloc : 8'h00; // R16 R17
			inq_idx_reg  <= 8'h00;
		end else if (load & is_inq) begin
			inq_left_reg <= inq_left_reg - 8'h01;
			inq_idx_reg  <= inq_idx_reg + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Disconnect and reselection

	wire [AW:0] full_lvl  = ratio_level(full_ratio_in); // R23
	wire [AW:0] empty_lvl = ratio_level(empty_ratio_in); // R23
	wire        rd_empty  = is_rd & (avail == '0) & ~ov_reg & (blocks_left_reg != '0);
	wire        wr_stuck  = is_wr & (buf_full | ((bus_left_reg == '0) & ((occ_reg != '0) | ov_reg)));
	wire        go_disc   = disc_ok_reg & ~disc_reg & (rd_empty | wr_stuck); // R5 R6 R13
	wire        rd_trig   = (occ_reg >= full_lvl) | (blocks_left_reg == '0); // R7
	wire        wr_trig   = (bus_left_reg != '0) ? (occ_reg <= empty_lvl)
		: ((occ_reg == '0) & ~ov_reg); // R14
	wire        go_resel  = disc_reg & ~resel_reg & ((is_rd & rd_trig) | (is_wr & wr_trig));
	wire        reconnect = resel_reg & reselect_done_in;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			disc_ok_reg <= 1'b0;
		end else if (ident_valid_in) begin
			disc_ok_reg <= ident_msg_in[DISC_BIT]; // R5
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			disc_reg  <= 1'b0;
			resel_reg <= 1'b0;
		end else begin
			disc_reg  <= go_disc | (disc_reg & ~reconnect); // R6 R13
			resel_reg <= go_resel | (resel_reg & ~reconnect); // R7 R8 R14
		end
	end

	assign disconnect_out   = disc_reg;
	assign reselect_req_out = resel_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Command sequencing

	wire rd_fin  = is_rd & (blocks_left_reg == '0) & (occ_reg == '0) & ~ov_reg & ~disc_reg; // R4
	wire wr_fin  = is_wr & (bus_left_reg == '0) & (occ_reg == '0) & ~ov_reg & ~disc_reg;
	wire inq_fin = is_inq & (inq_left_reg == 8'h00) & ~ov_reg; // R17

	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_IDLE: begin
				if (cmd_take) begin
					if (op_read) begin
						st_next = ST_READ;
					end else if (op_write) begin
						st_next = ST_WRITE;
					end else if (op_seek) begin
						st_next = ST_SEEK; // R15
					end else if (op_inq) begin
						st_next = ST_INQ;
					end else begin
						st_next = ST_DONE;
					end
				end
			end
			ST_READ:  st_next = rd_fin ? ST_DONE : ST_READ;
			ST_WRITE: st_next = wr_fin ? ST_DONE : ST_WRITE;
			ST_SEEK:  st_next = ST_DONE;
			ST_INQ:   st_next = inq_fin ? ST_DONE : ST_INQ;
			ST_DONE:  st_next = ST_IDLE;
			default:  st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			st_reg    <= ST_IDLE;
			seek_reg  <= 1'b0;
			start_reg <= 1'b0;
			xfer_reg  <= '0;
		end else begin
			st_reg    <= st_next;
			seek_reg  <= cmd_take & op_seek; // R15
			start_reg <= cmd_take & (op_read | op_write);
			if (cmd_take & (op_read | op_write | op_seek)) begin
				xfer_reg <= '{lba: cmd_lba, blocks: op_seek ? 9'h000 : cmd_blocks}; // R10
			end
		end
	end

	assign cmd_ready_out  = (st_reg == ST_IDLE);
	assign cmd_done_out   = (st_reg == ST_DONE);
	assign seek_req_out   = seek_reg;
	assign xfer_start_out = start_reg;
	assign xfer_out       = xfer_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_seek_then_done;
		seek_req_out ##1 cmd_done_out;
	endsequence

	sequence s_quiet_inquiry;
		!bus_rd_valid_out ##1 (cmd_done_out && !bus_rd_valid_out);
	endsequence

	property p_commit_only;
		is_rd && avail == '0 |=> !$rose(ov_reg) || $past(is_inq);
	endproperty
	a_commit_only: assert property (p_commit_only) else $error("unfetched byte sent"); // R2

	property p_full_pause;
		is_rd && buf_full |-> !disk_rd_ready_out;
	endproperty
	a_full_pause: assert property (p_full_pause) else $error("disk fill past full"); // R3

	property p_bus_full;
		buf_full |-> !bus_wr_ready_out;
	endproperty
	a_bus_full: assert property (p_bus_full) else $error("bus data taken when full"); // R11

	property p_no_disc;
		!disc_ok_reg && !disc_reg |=> !disconnect_out;
	endproperty
	a_no_disc: assert property (p_no_disc) else $error("disconnect not permitted"); // R5

	property p_read_disc;
		disc_ok_reg && !disc_reg && rd_empty |=> disconnect_out && !bus_rd_valid_out;
	endproperty
	a_read_disc: assert property (p_read_disc) else $error("read did not disconnect"); // R6

	property p_read_resel;
		is_rd && disc_reg && !resel_reg && occ_reg >= full_lvl |=> reselect_req_out;
	endproperty
	a_read_resel: assert property (p_read_resel) else $error("read reselect missed"); // R7

	property p_write_hold;
		is_wr && disc_reg && !resel_reg && bus_left_reg != '0 && occ_reg > empty_lvl
			|=> !reselect_req_out;
	endproperty
	a_write_hold: assert property (p_write_hold) else $error("early write reselect"); // R14

	property p_zero_len;
		cmd_take && (op_write || op_read) && cdb_in.length == 8'h00
			|=> xfer_out.blocks == ZERO_LEN_BLOCKS && xfer_start_out;
	endproperty
	a_zero_len: assert property (p_zero_len) else $error("zero length not 256"); // R9

	property p_seek;
		cmd_take && op_seek |=> s_seek_then_done;
	endproperty
	a_seek: assert property (p_seek) else $error("seek sequence wrong"); // R15

	property p_alloc_zero;
		cmd_take && op_inq && cdb_in.length == 8'h00 |=> s_quiet_inquiry;
	endproperty
	a_alloc_zero: assert property (p_alloc_zero) else $error("data for zero allocation"); // R16

endmodule : dtrwb_core

// ===== test/dtrwb_initiator.sv
`timescale 1ns/100ps
module dtrwb_initiator (
	// Clock, reset and bench control
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic        wr_go_in,
	input  wire logic [15:0] wait_in,
	// Device side
	input  wire logic        bus_rd_valid_in,
	input  wire logic        bus_wr_ready_in,
	input  wire logic        reselect_req_in,
	output logic             bus_rd_ready_out,
	output logic             bus_wr_valid_out,
	output logic [7:0]       bus_wr_data_out,
	output logic             reselect_done_out
);
	logic [15:0] cnt_reg;
	logic [15:0] sent_reg;
	logic [7:0]  last_reg;
	logic        take;
	assign bus_rd_ready_out  = 1'b1;
	assign bus_wr_valid_out  = wr_go_in;
	assign bus_wr_data_out   = wr_go_in ? sent_reg[7:0] : ~last_reg;
	assign take              = wr_go_in & bus_wr_ready_in;
	// Answer reselection after a chosen delay
	assign reselect_done_out = reselect_req_in && (cnt_reg == wait_in);
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cnt_reg <= 16'h0000;
			sent_reg <= 16'h0000;
			last_reg <= 8'h00;
		end else begin
			cnt_reg <= (reselect_req_in && !reselect_done_out) ? cnt_reg + 16'h0001 : 16'h0000;
			if (take) begin
				sent_reg <= sent_reg + 16'h0001;
				last_reg <= sent_reg[7:0];
			end
		end
	end
endmodule : dtrwb_initiator

// ===== test/testbench.sv
`timescale 1ns/100ps
module testbench;
	import dtrwb_pkg::*;
	localparam int BUF = 1024;
	localparam int BLK = 8;
	logic ref_clk_in, rst_in, cdb_valid_in, cmd_ready_out, cmd_done_out;
	dtrwb_cdb_type cdb_in;
	dtrwb_xfer_type xfer_out;
	logic ident_valid_in, disk_rd_valid_in, disk_blk_ok_in, disk_rd_ready_out;
	logic [7:0] ident_msg_in, full_ratio_in, empty_ratio_in, disk_rd_data_in;
	logic disk_wr_valid_out, disk_wr_ready_in, head_on_target_in, xfer_start_out;
	logic [7:0] disk_wr_data_out, bus_wr_data_in, bus_rd_data_out;
	logic seek_req_out, bus_wr_valid_in, bus_wr_ready_out, bus_rd_valid_out;
	logic bus_rd_ready_in, disconnect_out, reselect_req_out, reselect_done_in, wr_go;
	logic [10:0] buf_level_out, lvl;
	logic [15:0] resel_wait;
	logic [7:0] rx_q[$];
	logic [7:0] hdr[5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
	int mismatches, checked, dw_n, dw_bad, disc_seen;

	dtrwb_core #(.BUF_BYTES_P(BUF), .BLK_BYTES_P(BLK), .INQ_ADD_LEN_P(0)) uut (
		.ref_clk_in, .rst_in, .cdb_valid_in, .cdb_in, .cmd_ready_out, .cmd_done_out,
		.ident_valid_in, .ident_msg_in, .full_ratio_in, .empty_ratio_in,
		.disk_rd_valid_in, .disk_rd_data_in, .disk_blk_ok_in, .disk_rd_ready_out,
		.disk_wr_valid_out, .disk_wr_data_out, .disk_wr_ready_in, .head_on_target_in,
		.xfer_start_out, .seek_req_out, .xfer_out, .bus_wr_valid_in, .bus_wr_data_in,
		.bus_wr_ready_out, .bus_rd_valid_out, .bus_rd_data_out, .bus_rd_ready_in,
		.disconnect_out, .reselect_req_out, .reselect_done_in, .buf_level_out
	);
	dtrwb_initiator host (
		.ref_clk_in, .rst_in, .wr_go_in(wr_go), .wait_in(resel_wait),
		.bus_rd_valid_in(bus_rd_valid_out), .bus_wr_ready_in(bus_wr_ready_out),
		.reselect_req_in(reselect_req_out), .bus_rd_ready_out(bus_rd_ready_in),
		.bus_wr_valid_out(bus_wr_valid_in), .bus_wr_data_out(bus_wr_data_in),
		.reselect_done_out(reselect_done_in)
	);

	////////////////////////////////////////
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	// Transfer monitors
	always @(negedge ref_clk_in) begin
		if (bus_rd_valid_out === 1'b1 && bus_rd_ready_in === 1'b1)
			rx_q.push_back(bus_rd_data_out);
		if (disk_wr_valid_out === 1'b1 && disk_wr_ready_in === 1'b1) begin
			if (disk_wr_data_out !== dw_n[7:0])
				dw_bad++;
			dw_n++;
		end
		if (disconnect_out === 1'b1)
			disc_seen++;
	end
	initial begin
		#200000;
		mismatches++;
		final_report;
	end

	////////////////////////////////////////
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			$display("FAIL %s expected %0h seen %0h", nm, ex, got);
			mismatches++;
		end
	endtask : chk
	function logic sig(input int k);
		case (k)
			0: return cmd_done_out;
			1: return seek_req_out;
			2: return xfer_start_out;
			3: return reselect_req_out;
			4: return disconnect_out;
			default: return buf_level_out == BUF;
		endcase
	endfunction : sig
	task wait_for(input int k);
		int n;
		n = 0;
		while (sig(k) !== 1'b1 && n < 20000) begin
			@(negedge ref_clk_in);
			n++;
		end
		chk("wait", 1, sig(k));
	endtask : wait_for
	task send_cmd(input logic [7:0] op, b1, b2, b3, b4);
		@(posedge ref_clk_in);
		cdb_in <= {op, b1, b2, b3, b4, 8'h00};
		cdb_valid_in <= 1'b1;
		@(negedge ref_clk_in);
		while (cmd_ready_out !== 1'b1)
			@(negedge ref_clk_in);
		@(posedge ref_clk_in);
		cdb_valid_in <= 1'b0;
	endtask : send_cmd
	task ident(input logic [7:0] m);
		@(posedge ref_clk_in);
		ident_msg_in <= m;
		ident_valid_in <= 1'b1;
		@(posedge ref_clk_in);
		ident_valid_in <= 1'b0;
	endtask : ident
	task disk_blk(input logic [7:0] base, input logic ok);
		for (int i = 0; i < BLK; i++) begin
			@(posedge ref_clk_in);
			disk_rd_valid_in <= 1'b1;
			disk_rd_data_in <= base + i[7:0];
			disk_blk_ok_in <= ok;
			@(negedge ref_clk_in);
			while (disk_rd_ready_out !== 1'b1)
				@(negedge ref_clk_in);
		end
		@(posedge ref_clk_in);
		disk_rd_valid_in <= 1'b0;
	endtask : disk_blk
	task final_report;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	////////////////////////////////////////
	initial begin
		{rst_in, cdb_valid_in, ident_valid_in, disk_rd_valid_in, disk_blk_ok_in} = 5'h10;
		{disk_wr_ready_in, head_on_target_in, wr_go} = 3'h4;
		{cdb_in, ident_msg_in, full_ratio_in, empty_ratio_in, disk_rd_data_in} = '0;
		resel_wait = 16'h0010;
		repeat (5) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(negedge ref_clk_in);
		chk("ready", 1, cmd_ready_out);
		chk("level", 0, buf_level_out);
		// Seek ignores byte 4 and top bits of byte 1
		send_cmd(OP_SEEK, 8'hFF, 8'h45, 8'h67, 8'h9C);
		wait_for(1);
		chk("seek lba", 21'h1F4567, xfer_out.lba);
		@(negedge ref_clk_in);
		chk("seek done", 1, cmd_done_out);
		chk("seek data", 0, rx_q.size());
		// Query lengths: recommended, short, zero
		foreach (hdr[j]) begin
			if (j < 3) begin
				rx_q.delete();
				send_cmd(OP_INQUIRY, 8'h00, 8'h00, 8'h00, j == 0 ? 8'h82 : j == 1 ? 8'h02 : 8'h00);
				wait_for(0);
				repeat (2) @(negedge ref_clk_in);
				chk("inq count", j == 0 ? 5 : j == 1 ? 2 : 0, rx_q.size());
				foreach (rx_q[i])
					chk("inq byte", hdr[i], rx_q[i]);
			end
		end
		// Read without permission, first fetch bad
		ident(8'h00);
		rx_q.delete();
		disc_seen = 0;
		send_cmd(OP_READ, 8'hE3, 8'h45, 8'h67, 8'h02);
		wait_for(2);
		chk("rd lba", 21'h034567, xfer_out.lba);
		chk("rd blocks", 9'h002, xfer_out.blocks);
		disk_blk(8'h10, 1'b0);
		repeat (3) @(negedge ref_clk_in);
		chk("bad blk", 0, rx_q.size());
		disk_blk(8'h10, 1'b1);
		disk_blk(8'h20, 1'b1);
		wait_for(0);
		chk("rd count", 2 * BLK, rx_q.size());
		foreach (rx_q[i])
			chk("rd byte", i < BLK ? 8'h10 + i : 8'h18 + i, rx_q[i]);
		chk("no disc", 0, disc_seen);
		// Read 256 blocks with disconnect
		ident(8'h40);
		full_ratio_in <= 8'h40;
		empty_ratio_in <= 8'h40;
		resel_wait = 16'd1500;
		rx_q.delete();
		send_cmd(OP_READ, 8'h00, 8'h00, 8'h00, 8'h00);
		wait_for(2);
		chk("rd256", 9'h100, xfer_out.blocks);
		fork
			for (int j = 0; j < 256; j++) begin
				disk_blk(j * BLK, 1'b1);
				if (j == 0)
					repeat (20) @(negedge ref_clk_in);
			end
			begin
				wait_for(4);
				wait_for(3);
				lvl = buf_level_out;
				chk("resel lvl", 1, lvl >= 256 && lvl <= 258);
				repeat (100) @(negedge ref_clk_in);
				chk("keeps fill", 1, buf_level_out > lvl);
				wait_for(5);
				repeat (2) @(negedge ref_clk_in);
				chk("disk stall", 0, disk_rd_ready_out);
			end
		join
		wait_for(0);
		chk("rd256 count", 256 * BLK, rx_q.size());
		// Write 256 blocks, head away first
		resel_wait = 16'h0010;
		send_cmd(OP_WRITE, 8'h00, 8'h01, 8'h02, 8'h00);
		wait_for(2);
		chk("wr256", 9'h100, xfer_out.blocks);
		@(posedge ref_clk_in);
		wr_go <= 1'b1;
		wait_for(5);
		repeat (2) @(negedge ref_clk_in);
		chk("wr full", 0, bus_wr_ready_out);
		chk("head off", 0, dw_n);
		wait_for(4);
		@(posedge ref_clk_in);
		wr_go <= 1'b0;
		head_on_target_in <= 1'b1;
		wait_for(3);
		chk("reconn lvl", 1, buf_level_out <= 256);
		// Rest of the blocks once reconnected
		@(posedge ref_clk_in);
		wr_go <= 1'b1;
		wait_for(0);
		chk("disk count", 256 * BLK, dw_n);
		chk("disk data", 0, dw_bad);
		final_report;
	end
endmodule : testbench
